// File: pkg/serdes_lane_mux_pkg.sv
/*
  Shared constants, the lane selection type and the lane permission decode for the
  high-speed lane multiplexer that feeds the shared serial transceiver quad.
  Assumes every user imports the whole package.
*/
package serdes_lane_mux_pkg;

  localparam int LANE_COUNT = 4;
  localparam int LANE_IDX_W = 2;
  localparam int SATA_COUNT = 2;
  localparam int DATA_W = 20;
  localparam int SEL_W = 3;

  // Last lane that may carry the first USB controller, and the only lane of the second.
  localparam logic [LANE_IDX_W-1:0] USB_A_LAST_LANE = 2'h2;
  localparam logic [LANE_IDX_W-1:0] USB_B_LANE = 2'h3;
  // Offset between the two lanes that may carry the same SATA channel.
  localparam int SATA_ALT_OFFSET = 2;

  localparam logic [DATA_W-1:0] IDLE_WORD = 20'h00000;

  typedef enum logic [SEL_W-1:0] {
    LANE_IDLE = 3'h0,
    LANE_PCIE = 3'h1,
    LANE_SATA = 3'h2,
    LANE_DISPLAY = 3'h3,
    LANE_USB_A = 3'h4,
    LANE_USB_B = 3'h5,
    LANE_SGMII = 3'h6
  } lane_sel_t;

  // True when the selection names a controller that may own the given lane.
  function automatic logic lane_allows(input logic [SEL_W-1:0] sel,
                                       input logic [LANE_IDX_W-1:0] lane);
    logic ok;
    ok = 1'b0;
    case (sel)
      LANE_PCIE, LANE_SATA, LANE_DISPLAY, LANE_SGMII: ok = 1'b1;
      LANE_USB_A: ok = (lane <= USB_A_LAST_LANE);
      LANE_USB_B: ok = (lane == USB_B_LANE);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

// File: src/lane_route_slot.sv
/*
  Transmit side of one transceiver lane: picks the word of the controller that owns
  the lane and registers it together with the lane enable and the effective owner.
  Assumes the caller hands in, for this lane, the word of each candidate controller.
*/
`timescale 1ns/10ps
`default_nettype none

module lane_route_slot
  import serdes_lane_mux_pkg::*;
#(
  parameter logic [LANE_IDX_W-1:0] LANE = 2'h0
) (
  input wire logic core_clk_i, // Core clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic [SEL_W-1:0] sel_i, // Configured owner of this lane.
  input wire logic [DATA_W-1:0] pcie_tx_i, // PCIe lane word with this number.
  input wire logic [DATA_W-1:0] sata_tx_i, // SATA channel word for this lane.
  input wire logic [DATA_W-1:0] display_tx_i, // Display link word for this lane.
  input wire logic [DATA_W-1:0] usb_a_tx_i, // First USB controller word.
  input wire logic [DATA_W-1:0] usb_b_tx_i, // Second USB controller word.
  input wire logic [DATA_W-1:0] sgmii_tx_i, // SGMII port word with this number.
  output logic [DATA_W-1:0] lane_tx_o, // Registered word to the lane.
  output logic lane_tx_en_o, // Registered lane in use.
  output logic [SEL_W-1:0] owner_o // Registered effective owner.
);

  wire logic allowed;
  wire logic [SEL_W-1:0] next_owner;
  logic [DATA_W-1:0] next_tx;

  // A selection the lane cannot carry leaves the lane idle.
  assign allowed = lane_allows(sel_i, LANE);
  assign next_owner = allowed ? sel_i : LANE_IDLE;

  always_comb begin
    case (next_owner)
      LANE_PCIE: next_tx = pcie_tx_i;
      LANE_SATA: next_tx = sata_tx_i;
      LANE_DISPLAY: next_tx = display_tx_i;
      LANE_USB_A: next_tx = usb_a_tx_i;
      LANE_USB_B: next_tx = usb_b_tx_i;
      LANE_SGMII: next_tx = sgmii_tx_i;
      default: next_tx = IDLE_WORD;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lane_tx_o <= IDLE_WORD;
      lane_tx_en_o <= 1'b0;
      owner_o <= LANE_IDLE;
    end else begin
      lane_tx_o <= next_tx;
      lane_tx_en_o <= (next_owner != LANE_IDLE);
      owner_o <= next_owner;
    end
  end

endmodule

`default_nettype wire

// File: src/serdes_lane_mux.sv
/*
  High-speed lane multiplexer between the peripheral controllers and the four lanes
  of the shared serial transceiver. Lane ownership comes from configuration inputs;
  transmit words go out to the lanes and receive words come back to the owners
  other than the display link, each with one register stage.
  Assumes all inputs are synchronous to core_clk_i and the configuration is held
  steady while a lane carries traffic.
*/
// Overview of operation
// - Each lane routes to one configured controller.
// - Exactly four lanes, numbered zero to three.
// - PCIe lane n uses transceiver lane n.
// - SATA channel c on lane c or c+2.
// - Display lanes alternate; transmit only, no receive.
// - Fixed SGMII and second USB lanes; first USB on lanes zero to two.
`timescale 1ns/10ps
`default_nettype none

module serdes_lane_mux
  import serdes_lane_mux_pkg::*;
(
  input wire logic core_clk_i, // Core clock, 100 MHz.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic [LANE_COUNT-1:0][SEL_W-1:0] lane_sel_i, // Owner code per lane.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] pcie_tx_i, // PCIe lane words.
  output logic [LANE_COUNT-1:0][DATA_W-1:0] pcie_rx_o, // PCIe receive words.
  output logic [LANE_COUNT-1:0] pcie_rx_en_o, // PCIe lane connected.
  input wire logic [SATA_COUNT-1:0][DATA_W-1:0] sata_tx_i, // SATA channel words.
  output logic [SATA_COUNT-1:0][DATA_W-1:0] sata_rx_o, // SATA receive words.
  output logic [SATA_COUNT-1:0] sata_rx_en_o, // SATA channel connected.
  input wire logic [DATA_W-1:0] display_tx_lane_a_i, // Display first lane word.
  input wire logic [DATA_W-1:0] display_tx_lane_b_i, // Display second lane word.
  output logic [1:0] display_tx_en_o, // Display lanes a and b connected.
  input wire logic [DATA_W-1:0] usb_a_tx_i, // First USB transmit word.
  output logic [DATA_W-1:0] usb_a_rx_o, // First USB receive word.
  output logic usb_a_rx_en_o, // First USB connected.
  input wire logic [DATA_W-1:0] usb_b_tx_i, // Second USB transmit word.
  output logic [DATA_W-1:0] usb_b_rx_o, // Second USB receive word.
  output logic usb_b_rx_en_o, // Second USB connected.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] sgmii_tx_i, // SGMII port words.
  output logic [LANE_COUNT-1:0][DATA_W-1:0] sgmii_rx_o, // SGMII receive words.
  output logic [LANE_COUNT-1:0] sgmii_rx_en_o, // SGMII port connected.
  output logic [LANE_COUNT-1:0][DATA_W-1:0] lane_tx_o, // Words to the lanes.
  output logic [LANE_COUNT-1:0] lane_tx_en_o, // Lane carries a controller.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] lane_rx_i, // Words from the lanes.
  output logic [LANE_COUNT-1:0][SEL_W-1:0] lane_owner_o // Effective owner per lane.
);

  wire logic [LANE_COUNT-1:0] own_pcie;
  wire logic [LANE_COUNT-1:0] own_sata;
  wire logic [LANE_COUNT-1:0] own_display;
  wire logic [LANE_COUNT-1:0] own_usb_a;
  wire logic [LANE_COUNT-1:0] own_usb_b;
  wire logic [LANE_COUNT-1:0] own_sgmii;
  wire logic [LANE_COUNT-1:0][DATA_W-1:0] next_pcie_rx;
  wire logic [LANE_COUNT-1:0][DATA_W-1:0] next_sgmii_rx;
  wire logic [SATA_COUNT-1:0][DATA_W-1:0] next_sata_rx;
  wire logic [SATA_COUNT-1:0] next_sata_en;
  wire logic [1:0] next_display_en;
  logic [DATA_W-1:0] next_usb_a_rx;
  wire logic next_usb_a_en;
  wire logic [DATA_W-1:0] next_usb_b_rx;

  genvar l;
  generate
    for (l = 0; l < LANE_COUNT; l++) begin : g_lane
      wire logic ok;
      wire logic [DATA_W-1:0] display_word;

      // Even lanes carry the display second lane, odd lanes its first lane.
      assign display_word = ((l % 2) != 0) ? display_tx_lane_a_i : display_tx_lane_b_i;

      lane_route_slot #(
        .LANE(LANE_IDX_W'(l))
      ) u_slot (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .sel_i(lane_sel_i[l]),
        .pcie_tx_i(pcie_tx_i[l]),
        .sata_tx_i(sata_tx_i[l % SATA_COUNT]),
        .display_tx_i(display_word),
        .usb_a_tx_i(usb_a_tx_i),
        .usb_b_tx_i(usb_b_tx_i),
        .sgmii_tx_i(sgmii_tx_i[l]),
        .lane_tx_o(lane_tx_o[l]),
        .lane_tx_en_o(lane_tx_en_o[l]),
        .owner_o(lane_owner_o[l])
      );

      assign ok = lane_allows(lane_sel_i[l], LANE_IDX_W'(l));
      assign own_pcie[l] = ok && (lane_sel_i[l] == LANE_PCIE);
      assign own_sata[l] = ok && (lane_sel_i[l] == LANE_SATA);
      assign own_display[l] = ok && (lane_sel_i[l] == LANE_DISPLAY);
      assign own_usb_a[l] = ok && (lane_sel_i[l] == LANE_USB_A);
      assign own_usb_b[l] = ok && (lane_sel_i[l] == LANE_USB_B);
      assign own_sgmii[l] = ok && (lane_sel_i[l] == LANE_SGMII);

      assign next_pcie_rx[l] = own_pcie[l] ? lane_rx_i[l] : IDLE_WORD;
      assign next_sgmii_rx[l] = own_sgmii[l] ? lane_rx_i[l] : IDLE_WORD;
    end

    // Each SATA channel has a home lane and an alternate two lanes up; home wins.
    for (l = 0; l < SATA_COUNT; l++) begin : g_sata
      assign next_sata_en[l] = own_sata[l] | own_sata[l + SATA_ALT_OFFSET];
      assign next_sata_rx[l] = own_sata[l] ? lane_rx_i[l] :
                               own_sata[l + SATA_ALT_OFFSET] ?
                               lane_rx_i[l + SATA_ALT_OFFSET] : IDLE_WORD;
    end
  endgenerate

  // The display link has no receive path; only its lane use is reported.
  assign next_display_en[0] = own_display[1] | own_display[3];
  assign next_display_en[1] = own_display[0] | own_display[2];

  // The first USB controller takes the lowest lane that selects it.
  assign next_usb_a_en = |own_usb_a;
  always_comb begin
    next_usb_a_rx = IDLE_WORD;
    for (int i = LANE_COUNT - 1; i >= 0; i--) begin
      if (own_usb_a[i]) begin
        next_usb_a_rx = lane_rx_i[i];
      end
    end
  end

  assign next_usb_b_rx = own_usb_b[USB_B_LANE] ? lane_rx_i[USB_B_LANE] : IDLE_WORD;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pcie_rx_o <= '0;
    end else begin
      pcie_rx_o <= next_pcie_rx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pcie_rx_en_o <= '0;
    end else begin
      pcie_rx_en_o <= own_pcie;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sgmii_rx_o <= '0;
    end else begin
      sgmii_rx_o <= next_sgmii_rx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sgmii_rx_en_o <= '0;
    end else begin
      sgmii_rx_en_o <= own_sgmii;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sata_rx_o <= '0;
    end else begin
      sata_rx_o <= next_sata_rx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sata_rx_en_o <= '0;
    end else begin
      sata_rx_en_o <= next_sata_en;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      display_tx_en_o <= '0;
    end else begin
      display_tx_en_o <= next_display_en;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      usb_a_rx_o <= IDLE_WORD;
    end else begin
      usb_a_rx_o <= next_usb_a_rx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      usb_a_rx_en_o <= 1'b0;
    end else begin
      usb_a_rx_en_o <= next_usb_a_en;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      usb_b_rx_o <= IDLE_WORD;
    end else begin
      usb_b_rx_o <= next_usb_b_rx;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      usb_b_rx_en_o <= 1'b0;
    end else begin
      usb_b_rx_en_o <= own_usb_b[USB_B_LANE];
    end
  end

endmodule

`default_nettype wire

// File: tb/serdes_lane_mux_properties.sv
/* Port checker for serdes_lane_mux.
   Assumes one clock domain and rstn_i as the only disable. */
`timescale 1ns/10ps
`default_nettype none
module serdes_lane_mux_properties
  import serdes_lane_mux_pkg::*;
(
  input wire logic core_clk_i, // Clock.
  input wire logic rstn_i, // Reset, active low.
  input wire logic [LANE_COUNT-1:0][SEL_W-1:0] lane_sel_i, // Owner codes.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] pcie_tx_i, // PCIe words.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] pcie_rx_o, // PCIe receive.
  input wire logic [LANE_COUNT-1:0] pcie_rx_en_o, // PCIe connected.
  input wire logic [SATA_COUNT-1:0][DATA_W-1:0] sata_tx_i, // SATA words.
  input wire logic [DATA_W-1:0] display_tx_lane_a_i, // Display lane a.
  input wire logic [DATA_W-1:0] display_tx_lane_b_i, // Display lane b.
  input wire logic [DATA_W-1:0] usb_b_tx_i, // Second USB word.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] sgmii_tx_i, // SGMII words.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] lane_tx_o, // Lane words.
  input wire logic [LANE_COUNT-1:0] lane_tx_en_o, // Lanes in use.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] lane_rx_i, // Lane receive.
  input wire logic [LANE_COUNT-1:0][SEL_W-1:0] lane_owner_o // Owners.
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_sel(int n, int c);
    lane_sel_i[n] == c;
  endsequence
  for (genvar n = 0; n < LANE_COUNT; n++) begin : g_lane
    AST_PCIE_ROUTE: assert property (
      s_sel(n, 1) |=> lane_tx_o[n] == $past(pcie_tx_i[n]) && pcie_rx_en_o[n]
        && pcie_rx_o[n] == $past(lane_rx_i[n])) else $error("pcie lane route wrong");
    AST_SATA_ROUTE: assert property (
      s_sel(n, 2) |=> lane_tx_o[n] == $past(sata_tx_i[n % 2])) else $error("sata route wrong");
    AST_DISP_ROUTE: assert property (
      s_sel(n, 3) |=> lane_tx_o[n] == $past(n % 2 ? display_tx_lane_a_i : display_tx_lane_b_i))
      else $error("display route wrong");
    AST_SGMII_ROUTE: assert property (
      s_sel(n, 6) |=> lane_tx_o[n] == $past(sgmii_tx_i[n])) else $error("sgmii route wrong");
    AST_CODE_BAD: assert property (
      s_sel(n, 7) |=> !lane_tx_en_o[n] && lane_tx_o[n] == '0 && lane_owner_o[n] == '0)
      else $error("invalid code not idle");
    AST_OWNER_EN: assert property (
      1'b1 |=> lane_owner_o[n] == (lane_tx_en_o[n] ? $past(lane_sel_i[n]) : 3'h0))
      else $error("owner does not follow selection");
  end
  AST_USB_A_LAST: assert property (
    s_sel(3, 4) |=> !lane_tx_en_o[3]) else $error("first usb on lane 3");
  AST_USB_B_ONLY: assert property (
    s_sel(3, 5) |=> lane_tx_en_o[3] && lane_tx_o[3] == $past(usb_b_tx_i))
    else $error("second usb route wrong");
endmodule
bind serdes_lane_mux serdes_lane_mux_properties u_serdes_lane_mux_properties (.core_clk_i,
  .rstn_i, .lane_sel_i, .pcie_tx_i, .pcie_rx_o, .pcie_rx_en_o, .sata_tx_i,
  .display_tx_lane_a_i, .display_tx_lane_b_i, .usb_b_tx_i, .sgmii_tx_i, .lane_tx_o,
  .lane_tx_en_o, .lane_rx_i, .lane_owner_o);
`default_nettype wire

// File: tb/lane_far_end.sv
/* Transceiver lanes: each lane in use returns the inverse of what it is sent.
   Assumes the lane outputs of serdes_lane_mux. */
`timescale 1ns/10ps
`default_nettype none
module lane_far_end
  import serdes_lane_mux_pkg::*;
(
  input wire logic core_clk_i, // Clock.
  input wire logic rstn_i, // Reset, active low.
  input wire logic [LANE_COUNT-1:0][DATA_W-1:0] lane_tx_i, // Words sent.
  input wire logic [LANE_COUNT-1:0] lane_tx_en_i, // Lanes in use.
  output logic [LANE_COUNT-1:0][DATA_W-1:0] lane_rx_o // Words returned.
);
  logic [DATA_W-1:0] noise;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      noise <= 20'h5a5a5;
    end else begin
      noise <= ~noise + 20'h00001;
    end
  end
  // An unused lane returns a changing pattern so stale data cannot pass.
  always_comb begin
    for (int n = 0; n < LANE_COUNT; n++) begin
      lane_rx_o[n] = lane_tx_en_i[n] ? ~lane_tx_i[n] : noise;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/* Self-checking bench for serdes_lane_mux.
   Assumes one cycle of latency and held inputs. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import serdes_lane_mux_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [LANE_COUNT-1:0][SEL_W-1:0] lane_sel = '0;
  logic [LANE_COUNT-1:0][SEL_W-1:0] owner;
  logic [LANE_COUNT-1:0][DATA_W-1:0] pcie_tx, pcie_rx, sgmii_tx, sgmii_rx, lane_tx, lane_rx;
  logic [SATA_COUNT-1:0][DATA_W-1:0] sata_tx, sata_rx;
  logic [DATA_W-1:0] disp_a, disp_b, usb_a_tx, usb_a_rx, usb_b_tx, usb_b_rx;
  logic [LANE_COUNT-1:0] pcie_en, sgmii_en, lane_en;
  logic [SATA_COUNT-1:0] sata_en;
  logic [1:0] disp_en;
  logic usb_a_en, usb_b_en;
  int mismatches = 0;
  int check_count = 0;
  serdes_lane_mux u_serdes_lane_mux (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .lane_sel_i(lane_sel), .pcie_tx_i(pcie_tx), .pcie_rx_o(pcie_rx), .pcie_rx_en_o(pcie_en),
    .sata_tx_i(sata_tx), .sata_rx_o(sata_rx), .sata_rx_en_o(sata_en),
    .display_tx_lane_a_i(disp_a), .display_tx_lane_b_i(disp_b), .display_tx_en_o(disp_en),
    .usb_a_tx_i(usb_a_tx), .usb_a_rx_o(usb_a_rx), .usb_a_rx_en_o(usb_a_en),
    .usb_b_tx_i(usb_b_tx), .usb_b_rx_o(usb_b_rx), .usb_b_rx_en_o(usb_b_en),
    .sgmii_tx_i(sgmii_tx), .sgmii_rx_o(sgmii_rx), .sgmii_rx_en_o(sgmii_en),
    .lane_tx_o(lane_tx), .lane_tx_en_o(lane_en), .lane_rx_i(lane_rx), .lane_owner_o(owner));
  lane_far_end u_lane_far_end (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .lane_tx_i(lane_tx), .lane_tx_en_i(lane_en), .lane_rx_o(lane_rx));
  function automatic logic [DATA_W-1:0] exp_word(input logic [SEL_W-1:0] c, input int n);
    case (c)
      3'h1: return pcie_tx[n];
      3'h2: return sata_tx[n % 2];
      3'h3: return (n % 2) ? disp_a : disp_b;
      3'h4: return (n < 3) ? usb_a_tx : '0;
      3'h5: return (n == 3) ? usb_b_tx : '0;
      3'h6: return sgmii_tx[n];
      default: return '0;
    endcase
  endfunction
  function automatic logic exp_ok(input logic [SEL_W-1:0] c, input int n);
    case (c)
      3'h1, 3'h2, 3'h3, 3'h6: return 1'b1;
      3'h4: return n < 3;
      3'h5: return n == 3;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apply(input logic [LANE_COUNT-1:0][SEL_W-1:0] sel);
    lane_sel = sel;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  task automatic check_lanes;
    logic [DATA_W-1:0] w;
    for (int n = 0; n < LANE_COUNT; n++) begin
      w = exp_word(lane_sel[n], n);
      chk(lane_tx[n], w);
      chk(lane_en[n], exp_ok(lane_sel[n], n));
      chk(owner[n], exp_ok(lane_sel[n], n) ? lane_sel[n] : 3'h0);
    end
  endtask
  task automatic t_pcie;
    apply({4{3'h1}});
    check_lanes();
    for (int n = 0; n < LANE_COUNT; n++) begin
      chk(pcie_rx[n], ~pcie_tx[n]);
    end
    chk(pcie_en, 4'hf);
  endtask
  task automatic t_sata;
    apply({4{3'h2}});
    check_lanes();
    chk(sata_rx[0], ~sata_tx[0]);
    chk(sata_rx[1], ~sata_tx[1]);
    chk(sata_en, 2'h3);
  endtask
  task automatic t_disp;
    apply({4{3'h3}});
    check_lanes();
    chk(disp_en, 2'h3);
  endtask
  task automatic t_usb;
    apply({3'h5, 3'h4, 3'h4, 3'h4});
    check_lanes();
    chk(usb_a_rx, ~usb_a_tx);
    chk(usb_b_rx, ~usb_b_tx);
    chk({usb_a_en, usb_b_en}, 2'h3);
    apply({3'h4, 3'h7, 3'h5, 3'h5});
    check_lanes();
    chk({usb_a_en, usb_b_en}, 2'h0);
  endtask
  task automatic t_mix;
    apply({3'h2, 3'h2, 3'h1, 3'h1});
    check_lanes();
    chk(sata_rx[0], ~sata_tx[0]);
    chk(sata_rx[1], ~sata_tx[1]);
    chk(sata_en, 2'h3);
    chk(pcie_en, 4'h3);
    chk(pcie_rx[2], 20'h00000);
    chk(pcie_rx[3], 20'h00000);
    apply({3'h5, 3'h4, 3'h6, 3'h6});
    check_lanes();
    chk(usb_a_rx, ~usb_a_tx);
    chk({usb_a_en, usb_b_en}, 2'h3);
    chk(sgmii_en, 4'h3);
    chk(sgmii_rx[2], 20'h00000);
    apply({3'h0, 3'h0, 3'h3, 3'h0});
    check_lanes();
    chk(disp_en, 2'h1);
  endtask
  task automatic t_sgmii_reset;
    apply({4{3'h6}});
    check_lanes();
    for (int n = 0; n < LANE_COUNT; n++) begin
      chk(sgmii_rx[n], ~sgmii_tx[n]);
    end
    chk(sgmii_en, 4'hf);
    rstn_i = 1'b0;
    #1;
    chk(lane_en, 4'h0);
    chk(owner, 12'h000);
    @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    pcie_tx = {20'h13333, 20'h12222, 20'h11111, 20'h10000};
    sgmii_tx = {20'h63333, 20'h62222, 20'h61111, 20'h60000};
    sata_tx = {20'h2bbbb, 20'h2aaaa};
    disp_a = 20'h3aaaa;
    disp_b = 20'h3bbbb;
    usb_a_tx = 20'h4aaaa;
    usb_b_tx = 20'h5bbbb;
    repeat (16) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    t_pcie();
    t_sata();
    t_disp();
    t_usb();
    t_mix();
    t_sgmii_reset();
    t_pcie();
    wrap_up();
  end
endmodule
`default_nettype wire
